/* File: dv/dmmc_monitor.sv */
// checker: link and sequencer handshake properties
`timescale 1ns/1ns
`default_nettype none
module dmmc_monitor
   import dmmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic valid,
   input wire logic ready,
   input wire logic [DMMC_DW-1:0] word,
   input wire logic first,
   input wire logic start,
   input wire logic busy,
   input wire logic done,
   input wire logic mem_rd,
   input wire logic mem_ack,
   input wire logic [DMMC_AW-1:0] mem_addr,
   input wire logic [DMMC_DW-1:0] mem_data,
   input wire logic order_lsb_first,
   input wire logic dbl_valid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_ack;
      mem_rd && mem_ack;
   endsequence
   sequence s_second;
      valid && ready && !first;
   endsequence
   start_taken_a: assert property (start && !busy |=> busy)
      else $error("start lost");
   fetch_hold_a: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
      else $error("fetch dropped");
   word_forward_a: assert property (s_ack |=> valid && word == $past(mem_data))
      else $error("word not offered");
   no_overlap_a: assert property (valid |-> !mem_rd)
      else $error("fetch before accept");
   pair_fill_a: assert property (s_second |=> dbl_valid)
      else $error("pair not filled");
   done_once_a: assert property (done |=> !done && !busy)
      else $error("done too long");
   order_reset_a: assert property ($fell(rst) |-> !order_lsb_first)
      else $error("order bit not cleared");
   idle_quiet_a: assert property (!busy |-> !mem_rd)
      else $error("fetch while idle");
endmodule
`default_nettype wire

/* File: dv/double_move_mem_to_coproc_tb.sv */
// testbench: double moves from memory into the coprocessor end
`timescale 1ns/1ns
`default_nettype none
module double_move_mem_to_coproc_tb;
   import dmmc_pkg::*;
   typedef struct {dmmc_mode_t m; logic [31:0] p; logic [4:0] n; logic o;} dmmc_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   dmmc_mode_t mode = DMMC_POST_REG;
   logic [31:0] ptr = 32'h0;
   logic [4:0] cnt = 5'h00;
   logic [4:0] xfer = 5'h00;
   logic [4:0] dst = 5'h03;
   logic cfg_wr = 1'b0;
   logic cfg_order = 1'b0;
   logic mem_ack = 1'b0;
   logic [31:0] mem_data = 32'h0;
   logic slow = 1'b0;
   logic seen = 1'b0;
   logic busy, done, mem_rd, ord, dv;
   logic [31:0] ptr_out, mem_addr;
   logic [7:0] states;
   logic [63:0] dd;
   logic [4:0] dr;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   dmmc_row_t rows[6];
   dmmc_if u_dmmc_if();
   dmmc_seq u_dmmc_seq(.clk(clk), .rst(rst), .lnk(u_dmmc_if.seq), .start(start), .mode(mode),
      .src_pointer_reg(ptr), .count_reg(cnt), .transfers(xfer), .cop_dest_reg(dst),
      .busy(busy), .done(done), .ptr_out(ptr_out), .states_out(states), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data));
   dmmc_cop u_dmmc_cop(.clk(clk), .rst(rst), .lnk(u_dmmc_if.cop), .cfg_wr(cfg_wr),
      .cfg_order(cfg_order), .order_lsb_first(ord), .dbl_valid(dv), .dbl_data(dd), .dbl_reg(dr));
   dmmc_monitor u_dmmc_monitor(.clk(clk), .rst(rst), .valid(u_dmmc_if.valid),
      .ready(u_dmmc_if.ready), .word(u_dmmc_if.word), .first(u_dmmc_if.first), .start(start),
      .busy(busy), .done(done), .mem_rd(mem_rd), .mem_ack(mem_ack), .mem_addr(mem_addr),
      .mem_data(mem_data), .order_lsb_first(ord), .dbl_valid(dv));
   always #5 clk = ~clk;
   // memory answers at once, or a cycle late when slow
   always @(negedge clk)
   begin
      mem_ack <= mem_rd && (!slow || seen);
      seen <= mem_rd && !mem_ack;
      mem_data <= mem_addr ^ 32'h5A5A0F0F;
   end
   task automatic test_done;
      $display("tests %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         num_errors++;
         test_done;
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] dat(input dmmc_row_t r, input int i);
      dat = ((r.m == DMMC_PRE_CONST) ? r.p - 32'(32 * (i + 1)) : r.p + 32'(32 * i)) ^ 32'h5A5A0F0F;
   endfunction
   task automatic run(input dmmc_row_t r, input logic again);
      int w;
      int k;
      int c;
      w = (r.m == DMMC_POST_REG) ? ((r.n == 5'h00) ? 32 : int'(r.n))
         : ((r.n[3:0] == 4'h0) ? 32 : 2 * int'(r.n[3:0]));
      k = 0;
      c = 0;
      cfg_wr = 1'b1;
      cfg_order = r.o;
      mode = r.m;
      ptr = r.p;
      cnt = r.n;
      xfer = (r.n[3:0] == 4'h0) ? 5'h00 : {r.n[3:0], 1'b0};
      @(negedge clk);
      cfg_wr = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      while (done !== 1'b1 && c < 400)
      begin
         @(negedge clk);
         c++;
         // a second start mid-move must be ignored
         start = again && c == 3;
         if (dv === 1'b1)
         begin
            chk(dd, r.o ? {dat(r, 2*k+1), dat(r, 2*k)} : {dat(r, 2*k), dat(r, 2*k+1)});
            chk(64'(dr), 64'(dst + k));
            k++;
         end
      end
      chk(64'(done), 64'h1);
      chk(64'(k), 64'(w / 2));
      chk(64'(ptr_out), 64'((r.m == DMMC_PRE_CONST) ? r.p - 32'(32 * w) : r.p + 32'(32 * w)));
      if (!slow)
         chk(64'(states), 64'(4 + w + (r.p[4:0] != 5'h00)));
      repeat (2) @(negedge clk);
      chk(64'(busy), 64'h0);
      $display("test done: mode %0d words %0d", r.m, w);
   endtask
   initial
   begin
      rows[0] = '{DMMC_POST_REG, 32'h00000100, 5'h02, 1'b0};
      rows[1] = '{DMMC_POST_REG, 32'h00000204, 5'h00, 1'b1};
      rows[2] = '{DMMC_POST_CONST, 32'h00001000, 5'h01, 1'b0};
      rows[3] = '{DMMC_POST_CONST, 32'h00003000, 5'h00, 1'b1};
      rows[4] = '{DMMC_PRE_CONST, 32'h00002000, 5'h0F, 1'b0};
      rows[5] = '{DMMC_PRE_CONST, 32'h00002011, 5'h01, 1'b1};
      repeat (12) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(64'(ord), 64'h0);
      $display("test done: reset");
      foreach (rows[i])
         run(rows[i], 1'b0);
      slow = 1'b1;
      run(rows[2], 1'b1);
      run(rows[4], 1'b0);
      // reset in mid-move drops the move and the order bit
      cfg_wr = 1'b1;
      cfg_order = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (3) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(64'(ord), 64'h0);
      chk(64'(busy), 64'h0);
      chk(64'(mem_rd), 64'h0);
      $display("test done: reset mid-move");
      test_done;
   end
endmodule
`default_nettype wire

/* File: rtl/dmmc_cop.sv */
// coprocessor end: word order bit and double assembly
`timescale 1ns/1ns
`default_nettype none
module dmmc_cop
   import dmmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   dmmc_if.cop lnk,
   input wire logic cfg_wr,
   input wire logic cfg_order,
   output logic order_lsb_first,
   output logic dbl_valid,
   output logic [2*DMMC_DW-1:0] dbl_data,
   output logic [DMMC_CRW-1:0] dbl_reg
);
   logic order_q, order_d, half_q, half_d, dv_q, dv_d;
   logic [DMMC_DW-1:0] hold_q, hold_d;
   logic [2*DMMC_DW-1:0] dd_q, dd_d;
   logic [DMMC_CRW-1:0] dr_q, dr_d;
   always_comb
   begin
      order_d = order_q;
      if (cfg_wr)
         order_d = cfg_order; // see RULE_15
      half_d = half_q;
      hold_d = hold_q;
      dv_d = 1'b0;
      dd_d = dd_q;
      dr_d = dr_q;
      if (lnk.valid)
      begin
         if (lnk.first)
         begin
            hold_d = lnk.word;
            half_d = 1'b1;
         end
         else if (half_q)
         begin
            half_d = 1'b0;
            dv_d = 1'b1;
            dr_d = lnk.dest;
            // order 1: low half first, 0: high half first
            if (order_q) // see RULE_06
               dd_d = {lnk.word, hold_q};
            else // see RULE_07
               dd_d = {hold_q, lnk.word};
         end
      end
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         order_q <= DMMC_ORDER_RESET; // see RULE_08
         half_q <= 1'b0;
         hold_q <= '0;
         dv_q <= 1'b0;
         dd_q <= '0;
         dr_q <= '0;
      end
      else
      begin
         order_q <= order_d;
         half_q <= half_d;
         hold_q <= hold_d;
         dv_q <= dv_d;
         dd_q <= dd_d;
         dr_q <= dr_d;
      end
   end
   assign lnk.ready = 1'b1;
   assign order_lsb_first = order_q;
   assign dbl_valid = dv_q;
   assign dbl_data = dd_q;
   assign dbl_reg = dr_q;
endmodule
`default_nettype wire

/* File: rtl/dmmc_if.sv */
// interface: word link between sequencer and coprocessor
`timescale 1ns/1ns
`default_nettype none
interface dmmc_if;
   import dmmc_pkg::*;
   logic valid;
   logic ready;
   logic [DMMC_DW-1:0] word;
   logic [DMMC_CRW-1:0] dest;
   logic first;
   modport seq (output valid, output word, output dest, output first, input ready);
   modport cop (input valid, input word, input dest, input first, output ready);
endinterface
`default_nettype wire

/* File: rtl/dmmc_pkg.sv */
// package: constants and types for the double move to coprocessor
package dmmc_pkg;
   localparam int DMMC_AW = 32;
   localparam int DMMC_DW = 32;
   localparam int DMMC_CRW = 5;
   localparam logic [DMMC_AW-1:0] DMMC_WORD_BITS = 32'h00000020;
   localparam logic [4:0] DMMC_RCNT_ZERO_WORDS = 5'h00;
   localparam logic [5:0] DMMC_RCNT_FULL = 6'h20;
   localparam logic [4:0] DMMC_XFER_FULL = 5'h00;
   localparam logic DMMC_STATE_LAST_PHASE = 1'b1;
   localparam logic [5:0] DMMC_CONST_FULL = 6'h20;
   localparam logic [4:0] DMMC_ALIGN_MASK = 5'h1F;
   localparam logic [7:0] DMMC_BASE_STATES = 8'h05;
   localparam logic [7:0] DMMC_UNALIGN_EXTRA = 8'h01;
   localparam logic DMMC_ORDER_RESET = 1'b0;
   typedef enum logic [1:0] {DMMC_POST_REG, DMMC_POST_CONST, DMMC_PRE_CONST} dmmc_mode_t;
   typedef enum {DMMC_IDLE, DMMC_SETUP, DMMC_FETCH, DMMC_OFFER, DMMC_DONE} dmmc_state_t;
endpackage

/* File: rtl/dmmc_seq.sv */
// processor end: sequencer for double moves from memory to coprocessor
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE_01 - register count zero means 32 words
// RULE_02 - register count 1..31 moves that many words
// RULE_03 - software gives even register count
// RULE_04 - post-increment adds 32 after each word
// RULE_05 - destination advances after every word pair
// RULE_06 - order bit 1: low half first
// RULE_07 - order bit 0: high half first
// RULE_08 - order bit resets to 0
// RULE_09 - constant count is 1 to 16 doubles
// RULE_10 - transfers field 0 means 16, else 2*count
// RULE_11 - pre-decrement subtracts 32 before each fetch
// RULE_12 - pre-decrement pointer starts past first double
// RULE_13 - post-increment pointer starts at first word
// RULE_14 - timing 5 plus 2n-1, one more unaligned
// RULE_15 - software clears order bit for high-first
// RULE_16 - wait for coprocessor accept before next fetch
module dmmc_seq
   import dmmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   dmmc_if.seq lnk,
   input wire logic start,
   input wire dmmc_mode_t mode,
   input wire logic [DMMC_AW-1:0] src_pointer_reg,
   input wire logic [4:0] count_reg,
   input wire logic [4:0] transfers,
   input wire logic [DMMC_CRW-1:0] cop_dest_reg,
   output logic busy,
   output logic done,
   output logic [DMMC_AW-1:0] ptr_out,
   output logic [7:0] states_out,
   output logic mem_rd,
   output logic [DMMC_AW-1:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [DMMC_DW-1:0] mem_data
);
   dmmc_state_t st_q, st_d;
   logic [DMMC_AW-1:0] ptr_q, ptr_d, addr_q, addr_d;
   logic [5:0] left_q, left_d;
   logic [DMMC_CRW-1:0] dest_q, dest_d;
   logic pre_q, pre_d, first_q, first_d, rd_q, rd_d;
   logic busy_q, busy_d, done_q, done_d, v_q, v_d;
   logic [DMMC_DW-1:0] word_q, word_d;
   logic [7:0] budget_q, budget_d, used_q, used_d;
   logic phase_q, phase_d, tick;

   // decodes the constant-count transfers field into words
   // field already holds twice the double count, i.e. the word count
   function automatic logic [5:0] words_of_field(input logic [4:0] f);
      if (f == DMMC_XFER_FULL)
         return DMMC_CONST_FULL; // see RULE_10
      return {1'b0, f}; // see RULE_09
   endfunction

   always_comb
   begin
      st_d = st_q;
      ptr_d = ptr_q;
      addr_d = addr_q;
      left_d = left_q;
      dest_d = dest_q;
      pre_d = pre_q;
      first_d = first_q;
      rd_d = 1'b0;
      busy_d = busy_q;
      done_d = 1'b0;
      v_d = v_q;
      word_d = word_q;
      budget_d = budget_q;
      used_d = used_q;
      // a machine state is two clocks: zero-wait words fit the budget
      tick = (st_q != DMMC_IDLE) && (phase_q == DMMC_STATE_LAST_PHASE);
      phase_d = phase_q;
      if (st_q != DMMC_IDLE)
         phase_d = tick ? 1'b0 : phase_q + 1'b1;
      if (tick)
         used_d = used_q + 8'h01; // see RULE_14
      case (st_q)
         DMMC_IDLE:
         begin
            if (start)
            begin
               ptr_d = src_pointer_reg; // see RULE_13
               dest_d = cop_dest_reg;
               pre_d = (mode == DMMC_PRE_CONST);
               first_d = 1'b1;
               busy_d = 1'b1;
               used_d = 8'h01;
               phase_d = 1'b0;
               if (mode == DMMC_POST_REG)
                  left_d = (count_reg == DMMC_RCNT_ZERO_WORDS) ? DMMC_RCNT_FULL
                     : {1'b0, count_reg}; // see RULE_01 RULE_02 RULE_03
               else
                  left_d = words_of_field(transfers);
               // nominal state budget, extra state when unaligned
               budget_d = DMMC_BASE_STATES + {2'b00, left_d} - 8'h01;
               if ((src_pointer_reg[4:0] & DMMC_ALIGN_MASK) != 5'h00)
                  budget_d = budget_d + DMMC_UNALIGN_EXTRA; // see RULE_14
               st_d = DMMC_SETUP;
            end
         end
         DMMC_SETUP:
         begin
            // pre-decrement pointer points past the double
            if (pre_q)
            begin
               ptr_d = ptr_q - DMMC_WORD_BITS; // see RULE_11 RULE_12
               addr_d = ptr_q - DMMC_WORD_BITS;
            end
            else
               addr_d = ptr_q;
            rd_d = 1'b1;
            st_d = DMMC_FETCH;
         end
         DMMC_FETCH:
         begin
            if (mem_ack)
            begin
               word_d = mem_data;
               v_d = 1'b1;
               if (!pre_q)
                  ptr_d = ptr_q + DMMC_WORD_BITS; // see RULE_04
               st_d = DMMC_OFFER;
            end
            else
               rd_d = 1'b1;
         end
         DMMC_OFFER:
         begin
            if (lnk.ready) // see RULE_16
            begin
               v_d = 1'b0;
               first_d = !first_q;
               if (!first_q)
                  dest_d = dest_q + 5'h01; // see RULE_05
               left_d = left_q - 6'h01;
               if (left_q == 6'h01)
                  st_d = DMMC_DONE;
               else
               begin
                  if (pre_q)
                  begin
                     ptr_d = ptr_q - DMMC_WORD_BITS; // see RULE_11
                     addr_d = ptr_q - DMMC_WORD_BITS;
                  end
                  else
                     addr_d = ptr_q;
                  rd_d = 1'b1;
                  st_d = DMMC_FETCH;
               end
            end
         end
         DMMC_DONE:
         begin
            // zero-wait link and memory land inside the budget
            if (tick && (used_q >= budget_q))
            begin
               used_d = used_q;
               busy_d = 1'b0;
               done_d = 1'b1;
               st_d = DMMC_IDLE;
            end
         end
         default:
            st_d = DMMC_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= DMMC_IDLE;
         ptr_q <= '0;
         addr_q <= '0;
         left_q <= '0;
         dest_q <= '0;
         pre_q <= 1'b0;
         first_q <= 1'b1;
         rd_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         v_q <= 1'b0;
         word_q <= '0;
         budget_q <= '0;
         used_q <= '0;
         phase_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         ptr_q <= ptr_d;
         addr_q <= addr_d;
         left_q <= left_d;
         dest_q <= dest_d;
         pre_q <= pre_d;
         first_q <= first_d;
         rd_q <= rd_d;
         busy_q <= busy_d;
         done_q <= done_d;
         v_q <= v_d;
         word_q <= word_d;
         budget_q <= budget_d;
         used_q <= used_d;
         phase_q <= phase_d;
      end
   end

   assign lnk.valid = v_q;
   assign lnk.word = word_q;
   assign lnk.dest = dest_q;
   assign lnk.first = first_q;
   assign busy = busy_q;
   assign done = done_q;
   assign ptr_out = ptr_q;
   assign states_out = used_q;
   assign mem_rd = rd_q;
   assign mem_addr = addr_q;
endmodule
`default_nettype wire
